// ### rtl/rxf_defs.svh
// Offsets, field positions, reset values and timing counts of the
// receiver front-end control block.
// Assumes a 10 MHz system clock.
`ifndef RXF_DEFS_SVH
`define RXF_DEFS_SVH

`define RXF_CLK_MHZ 10
// Register byte offsets
`define RXF_CTRL_OFS 4'h0
`define RXF_STATUS_OFS 4'h4
`define RXF_IRQ_STAT_OFS 4'h8
`define RXF_IRQ_MASK_OFS 4'hC
// CTRL fields
`define RXF_CTRL_RATE_BIT 0
`define RXF_CTRL_EQ_N_BIT 1
`define RXF_CTRL_RESET 2'h2
// STATUS fields
`define RXF_ST_LOSS_A_BIT 0
`define RXF_ST_LOSS_B_BIT 1
`define RXF_ST_SRC_LSB 2
`define RXF_ST_FLOCK_BIT 4
// Interrupt bits
`define RXF_IRQ_W 4
`define RXF_IRQ_LOSS_A 0
`define RXF_IRQ_LOSS_B 1
`define RXF_IRQ_SRC_CHG 2
`define RXF_IRQ_FLOCK 3
// Serial rates
`define RXF_RATE_LOW_KBAUD 531250
`define RXF_RATE_HIGH_KBAUD 1062500
// Recovered clock edges per byte clock half period
`define RXF_HALF_LOW 4'h5
`define RXF_HALF_HIGH 4'hA
// Loss-of-signal qualification
`define RXF_LOS_BIT_TIMES 80
`define RXF_LOS_CYCLES 4
// Reference frequency lock time
`define RXF_FLOCK_US 500
`define RXF_FLOCK_CYCLES (`RXF_FLOCK_US * `RXF_CLK_MHZ)

`endif

// ### rtl/rxf_pkg.sv
// Types shared by the receiver front-end control block.
// Assumes nothing of its surroundings.
package rxf_pkg;

  typedef enum logic [1:0] {
    RXF_LOCK_REF,
    RXF_LOCK_LINE,
    RXF_LOCK_LOOP
  } rxf_lock_src_t;

endpackage : rxf_pkg

// ### rtl/rxf_rx_front.sv
// Receiver front-end control: rate select, equalizer, loss-of-signal,
// input select, lock-source choice and byte clock generation.
// Assumes all inputs synchronous to clk_i and a classic Wishbone master.
//
// How it works
// R1: Rate select low gives 531.25 Mbaud, high gives 1062.5 Mbaud.
// R2: Equalizer enable low inserts the equalizer in the line path.
// R3: Loss flags rise after 4 cycles (80 bit times) below threshold.
// R4: Loss detectors watch only the raw line input, before the equalizer.
// R5: Loopback input skips the equalizer and feeds the selector.
// R6: Wrap high forwards loopback input, wrap low the line input.
// R7: Lock-reference low locks to the reference clock, whatever else.
// R8: Lock-reference high locks to the wrap-selected input.
// R9: Link-unused high with wrap low falls back to the reference clock.
// R10: With wrap high, loopback lock ignores link-unused.
// R11: Outside logic raises link-unused when it judges the line faulty.
// R12: Both byte clocks derive from the recovered serial clock.
// R13: Outside logic holds lock-reference low 500 us before release.
// R14: Lock source is decoded continuously from current input levels.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "rxf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rxf_rx_front
  import rxf_pkg::*;
#(
  parameter int FLOCK_CYCLES = `RXF_FLOCK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  // Serial inputs and level comparators
  input wire logic line_serial_in_i,
  input wire logic loopback_serial_source_i,
  input wire logic reference_clock_in_i,
  input wire logic line_below_thresh_a_i,
  input wire logic line_below_thresh_b_i,
  // Local lock control
  input wire logic lock_to_reference_n_i,
  input wire logic loopback_wrap_select_i,
  input wire logic link_unused_i,
  // Outputs
  output logic rate_select_o,
  output logic cable_equalizer_enable_n_o,
  output logic signal_loss_flag_a_o,
  output logic signal_loss_flag_b_o,
  output logic rx_serial_o,
  output logic [1:0] lock_source_o,
  output logic rx_byte_clock_0_o,
  output logic rx_byte_clock_1_o
);

  function automatic logic [2:0] los_step(input logic below,
                                          input logic [2:0] cnt);
    if (!below) begin
      los_step = 3'h0;
    end else if (cnt == 3'(`RXF_LOS_CYCLES)) begin
      los_step = cnt;
    end else begin
      los_step = cnt + 3'h1;
    end
  endfunction : los_step

  logic [1:0] ctrl_reg;
  logic [`RXF_IRQ_W-1:0] irq_stat_reg;
  logic [`RXF_IRQ_W-1:0] irq_stat_next;
  logic [`RXF_IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [2:0] los_a_reg;
  logic [2:0] los_b_reg;
  logic loss_a_reg;
  logic loss_b_reg;
  logic eq_stage_reg;
  logic rx_serial_reg;
  rxf_lock_src_t src_reg;
  logic rec_reg;
  logic [3:0] edge_cnt_reg;
  logic rbc_reg;
  logic [31:0] flock_cnt_reg;
  logic flock_reg;

  // Bus decode
  wire bus_req = cyc_i && stb_i && !ack_reg;
  wire wr_en = bus_req && we_i && sel_i[0];
  wire hit_ctrl = adr_i == `RXF_CTRL_OFS;
  wire hit_status = adr_i == `RXF_STATUS_OFS;
  wire hit_istat = adr_i == `RXF_IRQ_STAT_OFS;
  wire hit_imask = adr_i == `RXF_IRQ_MASK_OFS;

  // Lock source decode, purely from present levels
  rxf_lock_src_t lock_src;
  assign lock_src = !lock_to_reference_n_i ? RXF_LOCK_REF :        // R7 R14
                    loopback_wrap_select_i ? RXF_LOCK_LOOP :       // R8 R10
                    link_unused_i ? RXF_LOCK_REF : RXF_LOCK_LINE;  // R8 R9

  // Line path: equalizer stage in or out, loopback bypasses it
  wire line_path = ctrl_reg[`RXF_CTRL_EQ_N_BIT] ? line_serial_in_i :
                   eq_stage_reg;                                   // R2
  wire sel_serial = loopback_wrap_select_i ? loopback_serial_source_i :
                    line_path;                                     // R5 R6

  // Recovered serial clock follows the chosen lock source
  wire rec_src = (lock_src == RXF_LOCK_REF) ? reference_clock_in_i :
                 (lock_src == RXF_LOCK_LOOP) ? loopback_serial_source_i :
                 line_path;
  wire rec_edge = rec_src != rec_reg;
  wire [3:0] half = ctrl_reg[`RXF_CTRL_RATE_BIT] ? `RXF_HALF_HIGH :
                    `RXF_HALF_LOW;                                 // R1
  wire rbc_wrap = rec_edge && (edge_cnt_reg == half - 4'h1);

  wire los_a_full = los_step(line_below_thresh_a_i, los_a_reg) ==
                    3'(`RXF_LOS_CYCLES);
  wire los_b_full = los_step(line_below_thresh_b_i, los_b_reg) ==
                    3'(`RXF_LOS_CYCLES);
  wire flock_hit = !lock_to_reference_n_i &&
                   (flock_cnt_reg == 32'(FLOCK_CYCLES - 1));

  wire [`RXF_IRQ_W-1:0] irq_events = {flock_hit && !flock_reg,
                                      lock_src != src_reg,
                                      los_b_full && !loss_b_reg,
                                      los_a_full && !loss_a_reg};
  wire [`RXF_IRQ_W-1:0] irq_clr = (wr_en && hit_istat) ?
                                  dat_i[`RXF_IRQ_W-1:0] : '0;
  // Hardware set wins over a write-one clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_events;

  wire [31:0] status_word = {27'h0, flock_reg, 2'(src_reg),
                             loss_b_reg, loss_a_reg};
  wire [31:0] rd_data = hit_ctrl ? {30'h0, ctrl_reg} :
                        hit_status ? status_word :
                        hit_istat ? {28'h0, irq_stat_reg} :
                        hit_imask ? {28'h0, irq_mask_reg} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_data : dat_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `RXF_CTRL_RESET;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      if (wr_en && hit_ctrl) ctrl_reg <= dat_i[1:0];
      if (wr_en && hit_imask) irq_mask_reg <= dat_i[`RXF_IRQ_W-1:0];
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Loss-of-signal counters see only the raw line comparators
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      los_a_reg <= 3'h0;
      los_b_reg <= 3'h0;
      loss_a_reg <= 1'b0;
      loss_b_reg <= 1'b0;
    end else begin
      los_a_reg <= los_step(line_below_thresh_a_i, los_a_reg); // R3 R4
      los_b_reg <= los_step(line_below_thresh_b_i, los_b_reg); // R3 R4
      loss_a_reg <= los_a_full;                                 // R3
      loss_b_reg <= los_b_full;                                 // R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_stage_reg <= 1'b0;
      rx_serial_reg <= 1'b0;
      src_reg <= RXF_LOCK_REF;
    end else begin
      eq_stage_reg <= line_serial_in_i;
      rx_serial_reg <= sel_serial;                              // R6
      src_reg <= lock_src;
    end
  end

  // Byte clock divider counts edges of the recovered clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_reg <= 1'b0;
      edge_cnt_reg <= 4'h0;
      rbc_reg <= 1'b0;
    end else begin
      rec_reg <= rec_src;
      if (rbc_wrap) begin
        edge_cnt_reg <= 4'h0;
        rbc_reg <= !rbc_reg;                                    // R12
      end else if (rec_edge) begin
        edge_cnt_reg <= (edge_cnt_reg >= half) ? 4'h0 :
                        edge_cnt_reg + 4'h1;
      end
    end
  end

  // Reference hold timer: reports when frequency lock time has elapsed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flock_cnt_reg <= 32'h0;
      flock_reg <= 1'b0;
    end else if (lock_to_reference_n_i) begin
      flock_cnt_reg <= 32'h0;
      flock_reg <= 1'b0;
    end else if (flock_hit) begin
      flock_reg <= 1'b1;
    end else if (!flock_reg) begin
      flock_cnt_reg <= flock_cnt_reg + 32'h1;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
  assign rate_select_o = ctrl_reg[`RXF_CTRL_RATE_BIT];                // R1
  assign cable_equalizer_enable_n_o = ctrl_reg[`RXF_CTRL_EQ_N_BIT];   // R2
  assign signal_loss_flag_a_o = loss_a_reg;
  assign signal_loss_flag_b_o = loss_b_reg;
  assign rx_serial_o = rx_serial_reg;
  assign lock_source_o = 2'(src_reg);
  assign rx_byte_clock_0_o = rbc_reg;
  assign rx_byte_clock_1_o = !rbc_reg;                              // R12

  // Checks
  property p_los_a;
    @(posedge clk_i) disable iff (rst_i)
      line_below_thresh_a_i [*4] |=> signal_loss_flag_a_o;
  endproperty
  a_los_a: assert property (p_los_a) // R3
    else $error("loss flag A missing after four low cycles");

  property p_los_b_early;
    @(posedge clk_i) disable iff (rst_i)
      !line_below_thresh_b_i ##1 line_below_thresh_b_i [*3]
        |=> !signal_loss_flag_b_o;
  endproperty
  a_los_b_early: assert property (p_los_b_early) // R3
    else $error("loss flag B rose too early");

  property p_los_no_loop;
    @(posedge clk_i) disable iff (rst_i)
      !line_below_thresh_a_i |=> !signal_loss_flag_a_o;
  endproperty
  a_los_no_loop: assert property (p_los_no_loop) // R4
    else $error("loss flag A high without low line level");

  property p_ref_lock;
    @(posedge clk_i) disable iff (rst_i)
      !lock_to_reference_n_i |=> lock_source_o == 2'(RXF_LOCK_REF);
  endproperty
  a_ref_lock: assert property (p_ref_lock) // R7
    else $error("lock source not reference while lock-reference low");

  property p_line_lock;
    @(posedge clk_i) disable iff (rst_i)
      lock_to_reference_n_i && !loopback_wrap_select_i && !link_unused_i
        |=> lock_source_o == 2'(RXF_LOCK_LINE);
  endproperty
  a_line_lock: assert property (p_line_lock) // R8
    else $error("lock source not line input");

  property p_unused;
    @(posedge clk_i) disable iff (rst_i)
      lock_to_reference_n_i && !loopback_wrap_select_i && link_unused_i
        |=> lock_source_o == 2'(RXF_LOCK_REF);
  endproperty
  a_unused: assert property (p_unused) // R9
    else $error("link-unused did not return lock to reference");

  property p_loop_lock;
    @(posedge clk_i) disable iff (rst_i)
      lock_to_reference_n_i && loopback_wrap_select_i
        |=> lock_source_o == 2'(RXF_LOCK_LOOP);
  endproperty
  a_loop_lock: assert property (p_loop_lock) // R10
    else $error("loopback lock lost");

  property p_select;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> rx_serial_o == $past(sel_serial);
  endproperty
  a_select: assert property (p_select) // R6
    else $error("selected serial stream wrong");

  property p_loop_path;
    @(posedge clk_i) disable iff (rst_i)
      loopback_wrap_select_i
        |=> rx_serial_o == $past(loopback_serial_source_i);
  endproperty
  a_loop_path: assert property (p_loop_path) // R5
    else $error("loopback input not forwarded directly");

  property p_eq;
    @(posedge clk_i) disable iff (rst_i)
      !loopback_wrap_select_i && !cable_equalizer_enable_n_o
        |=> rx_serial_o == $past(line_serial_in_i, 2);
  endproperty
  a_eq: assert property (p_eq) // R2
    else $error("equalizer stage not in line path");

  property p_rbc;
    @(posedge clk_i) disable iff (rst_i)
      !rec_edge |=> $stable(rx_byte_clock_0_o);
  endproperty
  a_rbc: assert property (p_rbc) // R12
    else $error("byte clock moved without recovered clock edge");

  property p_rate_low;
    @(posedge clk_i) disable iff (rst_i)
      rec_edge && !rate_select_o &&
        edge_cnt_reg == `RXF_HALF_LOW - 4'h1 |=> $changed(rx_byte_clock_0_o);
  endproperty
  a_rate_low: assert property (p_rate_low) // R1
    else $error("byte clock half period wrong at the lower rate");

  property p_rate_high;
    @(posedge clk_i) disable iff (rst_i)
      rec_edge && rate_select_o &&
        edge_cnt_reg == `RXF_HALF_HIGH - 4'h1 |=> $changed(rx_byte_clock_0_o);
  endproperty
  a_rate_high: assert property (p_rate_high) // R1
    else $error("byte clock half period wrong at the higher rate");

  property p_no_latch;
    @(posedge clk_i) disable iff (rst_i)
      lock_to_reference_n_i && !loopback_wrap_select_i &&
        $stable(lock_to_reference_n_i) && $stable(loopback_wrap_select_i) &&
        $changed(link_unused_i) |=> $changed(lock_source_o);
  endproperty
  a_no_latch: assert property (p_no_latch) // R14
    else $error("lock source ignored a change of link-unused");

endmodule : rxf_rx_front

`default_nettype wire

// ### verif/rxf_line_model.sv
// Far-end serial transmitter model: line bit and two level comparators.
// Assumes clk_i is the block clock; quiet_i marks a dead line.
`timescale 1ns/1ps
`default_nettype none
module rxf_line_model (
  input wire logic clk_i,
  input wire logic quiet_i,
  output logic line_o,
  output logic below_a_o,
  output logic below_b_o
);
  logic bit_reg = 1'b0;
  // A dead line keeps changing so no stale bit passes for data
  always @(posedge clk_i) begin
    bit_reg <= quiet_i ? ~bit_reg : 1'($urandom);
  end
  assign line_o = bit_reg;
  assign below_a_o = quiet_i;
  assign below_b_o = quiet_i;
endmodule : rxf_line_model
`default_nettype wire

// ### verif/rxf_rx_front_tb_top.sv
// Self-checking bench for the receiver front-end control block.
// Assumes rxf_rx_front, rxf_line_model and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rxf_rx_front_tb_top;
  import rxf_pkg::*;
  localparam int FLOCK = 20;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, prev = 0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic loop_in = 0, ref_clk = 0, lock_n = 0, wrap = 0, unused = 0;
  logic quiet = 0, ack_o, irq_o, line, bel_a, bel_b, rate, eq_n;
  logic los_a, los_b, rx_ser, rx_byte_clock_0, rx_byte_clock_1;
  logic [1:0] src_o;
  int mismatches = 0, n_tests = 0, cycles = 0, nt = 0;
  bit q[$];

  rxf_rx_front #(.FLOCK_CYCLES(FLOCK)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .line_serial_in_i(line), .loopback_serial_source_i(loop_in),
    .reference_clock_in_i(ref_clk), .line_below_thresh_a_i(bel_a),
    .line_below_thresh_b_i(bel_b), .lock_to_reference_n_i(lock_n),
    .loopback_wrap_select_i(wrap), .link_unused_i(unused),
    .rate_select_o(rate), .cable_equalizer_enable_n_o(eq_n),
    .signal_loss_flag_a_o(los_a), .signal_loss_flag_b_o(los_b),
    .rx_serial_o(rx_ser), .lock_source_o(src_o),
    .rx_byte_clock_0_o(rx_byte_clock_0), .rx_byte_clock_1_o(rx_byte_clock_1));
  rxf_line_model far (.clk_i(clk_i), .quiet_i(quiet), .line_o(line),
    .below_a_o(bel_a), .below_b_o(bel_b));

  always #50 clk_i = ~clk_i;

  task close_out;
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out;
    end
  end

  // Classic single Wishbone cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                        input string n);
    wb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask : rd_chk

  function automatic logic [1:0] exp_src(logic ln, logic w, logic u);
    if (!ln) return 2'h0;
    if (w) return 2'h2;
    return u ? 2'h0 : 2'h1;
  endfunction : exp_src

  // Selected stream must appear d cycles late; loopback never trips loss
  task automatic path(input int d);
    q.delete();
    for (int i = 0; i < 24; i++) begin
      loop_in <= 1'($urandom);
      @(negedge clk_i);
      q.push_back(wrap ? loop_in : line);
      if (i > 4) `CHK("rx_serial", q[$-d], rx_ser)
      `CHK("loss_a", 1'b0, los_a)
      @(posedge clk_i);
    end
  endtask : path

  // Fifty reference clock toggles; e byte clock transitions expected
  task automatic bclk(input int e);
    nt = 0;
    for (int i = 0; i < 54; i++) begin
      if (i < 50) ref_clk <= ~ref_clk;
      @(negedge clk_i);
      `CHK("rx_byte_clock_1", ~rx_byte_clock_0, rx_byte_clock_1)
      if (rx_byte_clock_0 !== prev) nt++;
      prev = rx_byte_clock_0;
      @(posedge clk_i);
    end
    `CHK("rx_byte_clock_0 edges", e, nt)
  endtask : bclk

  initial begin
    void'($urandom(32'h5521));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("rx_byte_clock_1", 1'b1, rx_byte_clock_1)
    @(posedge clk_i);
    rd_chk(4'h0, 32'h2, "ctrl");
    rd_chk(4'hC, 32'h0, "mask");
    rd_chk(4'h2, 32'h0, "unmapped");
    wb(1'b1, 4'h0, 32'h1);
    `CHK("rate", 1'b1, rate)
    `CHK("eq_n", 1'b0, eq_n)
    sel <= 4'hE;
    wb(1'b1, 4'h0, 32'h0);
    sel <= 4'hF;
    rd_chk(4'h0, 32'h1, "ctrl lane");
    bclk(5);
    rd_chk(4'h4, 32'h10, "status");
    wb(1'b1, 4'h0, 32'h0);
    bclk(10);
    for (int k = 0; k < 8; k++) begin
      {lock_n, wrap, unused} <= 3'(k);
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("src", exp_src(lock_n, wrap, unused), src_o)
      @(posedge clk_i);
    end
    unused <= 1'b1;
    path(1);
    wrap <= 1'b0;
    unused <= 1'b0;
    path(2);
    wb(1'b1, 4'h0, 32'h3);
    path(1);
    wb(1'b1, 4'h8, 32'hF);
    wb(1'b1, 4'hC, 32'h0);
    quiet <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("loss_a", 1'b0, los_a)
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("loss_a", 1'b1, los_a)
    `CHK("loss_b", 1'b1, los_b)
    `CHK("irq masked", 1'b0, irq_o)
    @(posedge clk_i);
    wb(1'b1, 4'hC, 32'h3);
    `CHK("irq", 1'b1, irq_o)
    quiet <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("loss_b", 1'b0, los_b)
    @(posedge clk_i);
    `CHK("irq held", 1'b1, irq_o)
    wb(1'b1, 4'h8, 32'h3);
    `CHK("irq cleared", 1'b0, irq_o)
    close_out;
  end
endmodule : rxf_rx_front_tb_top
`default_nettype wire
